// File: pkg/pwg_regs.vh
// Command codes, field positions, reset values and timing for the write guard block.
// Assumes a 50 MHz logic clock; included by the single core file.
`ifndef PWG_REGS_VH
`define PWG_REGS_VH
`define PWG_CMD_OPERATION 8'h01
`define PWG_CMD_ON_OFF_CONFIG 8'h02
`define PWG_CMD_WRITE_GUARD 8'h10
`define PWG_CMD_STORE_ALL 8'h11
`define PWG_CMD_RESTORE_ALL 8'h12
`define PWG_CMD_FEATURE_REPORT 8'h19
`define PWG_CMD_ALERT_MASK 8'h1b
`define PWG_CMD_VOUT_COMMAND 8'h21
`define PWG_CMD_STATUS_BYTE 8'h78
`define PWG_CMD_STATUS_WORD 8'h79
`define PWG_CMD_STATUS_VOUT 8'h7a
`define PWG_CMD_STATUS_IOUT 8'h7b
`define PWG_CMD_STATUS_INPUT 8'h7c
`define PWG_CMD_STATUS_TEMP 8'h7d
`define PWG_CMD_STATUS_CML 8'h7e
`define PWG_CMD_STATUS_MFR 8'h80
`define PWG_GUARD_LVL1 8'h20
`define PWG_GUARD_LVL2 8'h40
`define PWG_GUARD_LVL3 8'h80
`define PWG_GUARD_MASK 8'he0
`define PWG_GUARD_RESET 8'h00
`define PWG_FEATURE_VALUE 8'hb0
`define PWG_MASK_RESET 8'h00
`define PWG_BUSY_MS 100
`define PWG_CLK_KHZ 50000
`define PWG_BUSY_CYCLES (`PWG_BUSY_MS * `PWG_CLK_KHZ)
`endif

// File: core/pwg_write_guard.v
// Write guard, store/restore sequencing, feature byte and alert-mask entry point.
// Assumes a bus front end that decodes commands into one-cycle strobes on ref_clk,
// and an EEPROM engine that answers each store or restore with a done pulse.
// The switching level is assumed to come from logic already on ref_clk.
`timescale 1ns/100ps
`include "pwg_regs.vh"
module pwg_write_guard #(
  parameter BUSY_CYCLES = `PWG_BUSY_CYCLES,
  parameter NUM_STATUS = 7
) (
  input wire ref_clk,
  input wire rst,
  input wire wr_strobe,
  input wire [7:0] wr_cmd,
  input wire [7:0] wr_data,
  input wire [7:0] wr_mask_code,
  input wire rd_strobe,
  input wire [7:0] rd_cmd,
  input wire [7:0] rd_mask_code,
  input wire [7:0] ee_guard_value,
  input wire ee_done,
  input wire ee_fail,
  input wire switching,
  input wire [8*NUM_STATUS-1:0] status_conditions,
  output reg [7:0] rd_data,
  output reg rd_valid,
  output reg wr_accept,
  output reg wr_block,
  output reg bus_nack,
  output reg bus_busy,
  output reg ee_store_req,
  output reg ee_restore_req,
  output reg [2:0] restore_allow,
  output reg fault_ignore,
  output reg restart_req,
  output reg [7:0] write_guard_level,
  output reg cml_flag,
  output reg mem_flag,
  output reg ivd_flag,
  output reg alert
);
// ===============================================
// Guard decode
localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_STORE = 2'd1;
localparam [1:0] ST_RESTORE = 2'd2;
localparam [1:0] ST_HOLD = 2'd3;
localparam [31:0] BUSY_MAX = BUSY_CYCLES - 1;
reg [1:0] state;
reg [31:0] busy_cnt;
reg [7:0] mask_mem [0:NUM_STATUS-1];
reg [2:0] wr_idx;
reg wr_idx_ok;
reg [2:0] rd_idx;
reg rd_idx_ok;
reg guard_ok;
reg permit;
reg [7:0] masked_hits;
integer i;
integer k;
reg [1:0] next_state;
reg [31:0] next_busy_cnt;
wire [7:0] guard_bits = write_guard_level & `PWG_GUARD_MASK;
// ===============================================
// Request qualification
// While the sequencer is away from idle the bus is deaf, so no read or write below is taken.
wire rd_go = rd_strobe && (state == ST_IDLE);
wire wr_go = wr_strobe && (state == ST_IDLE);
wire wr_take = wr_go && permit;
wire wr_is_guard = wr_take && (wr_cmd == `PWG_CMD_WRITE_GUARD);
wire wr_is_store = wr_take && (wr_cmd == `PWG_CMD_STORE_ALL);
wire wr_is_restore = wr_take && (wr_cmd == `PWG_CMD_RESTORE_ALL);
wire wr_is_mask = wr_take && (wr_cmd == `PWG_CMD_ALERT_MASK);
wire ee_finish = ee_done && ((state == ST_STORE) || (state == ST_RESTORE));
// A guard byte with two or more of its three level bits set is invalid.
wire guard_multi = (wr_data[7] & wr_data[6]) | (wr_data[7] & wr_data[5]) |
  (wr_data[6] & wr_data[5]);
function [3:0] status_index;
  input [7:0] code;
  begin
    case (code)
      `PWG_CMD_STATUS_WORD: status_index = 4'h8;
      `PWG_CMD_STATUS_VOUT: status_index = 4'h9;
      `PWG_CMD_STATUS_IOUT: status_index = 4'ha;
      `PWG_CMD_STATUS_INPUT: status_index = 4'hb;
      `PWG_CMD_STATUS_TEMP: status_index = 4'hc;
      `PWG_CMD_STATUS_CML: status_index = 4'hd;
      `PWG_CMD_STATUS_MFR: status_index = 4'he;
      default: status_index = 4'h0;
    endcase
  end
endfunction
always @* begin
  // Invalid multi-bit settings fall back to no protection, so all writes pass.
  guard_ok = (guard_bits == 8'h00) || (guard_bits == `PWG_GUARD_LVL1) ||
    (guard_bits == `PWG_GUARD_LVL2) || (guard_bits == `PWG_GUARD_LVL3);
  permit = 1'b1;
  if (guard_ok && guard_bits == `PWG_GUARD_LVL3) begin
    permit = (wr_cmd == `PWG_CMD_WRITE_GUARD);
  end else if (guard_ok && guard_bits == `PWG_GUARD_LVL2) begin
    permit = (wr_cmd == `PWG_CMD_WRITE_GUARD) || (wr_cmd == `PWG_CMD_OPERATION);
  end else if (guard_ok && guard_bits == `PWG_GUARD_LVL1) begin
    permit = (wr_cmd == `PWG_CMD_WRITE_GUARD) || (wr_cmd == `PWG_CMD_OPERATION) ||
      (wr_cmd == `PWG_CMD_ON_OFF_CONFIG) || (wr_cmd == `PWG_CMD_VOUT_COMMAND);
  end
  // Restore permission per group: {vout+onoff, operation, guard}; others need level 0.
  restore_allow = 3'b111;
  if (guard_ok && guard_bits != 8'h00) begin
    restore_allow = {guard_bits == `PWG_GUARD_LVL1,
      guard_bits != `PWG_GUARD_LVL3, 1'b1};
  end
  {wr_idx_ok, wr_idx} = status_index(wr_mask_code);
  {rd_idx_ok, rd_idx} = status_index(rd_mask_code);
  masked_hits = 8'h00;
  for (i = 0; i < NUM_STATUS; i = i + 1) begin
    masked_hits[i] = |(status_conditions[8*i +: 8] & ~mask_mem[i]);
  end
end
// ===============================================
// Sequencer next state
always @* begin
  next_state = state;
  next_busy_cnt = busy_cnt;
  case (state)
    ST_IDLE: begin
      // Only an accepted store or restore leaves idle; a blocked one changes nothing.
      if (wr_is_store) begin
        next_state = ST_STORE;
      end else if (wr_is_restore) begin
        next_state = ST_RESTORE;
      end
    end
    ST_STORE, ST_RESTORE: begin
      if (ee_done) begin
        next_busy_cnt = 32'h0;
        next_state = ST_HOLD;
      end
    end
    ST_HOLD: begin
      // The quiet time counts from the end of the EEPROM work, not from the command.
      if (busy_cnt >= BUSY_MAX) begin
        next_state = ST_IDLE;
      end else begin
        next_busy_cnt = busy_cnt + 32'h1;
      end
    end
    default: begin
      next_state = ST_IDLE;
      next_busy_cnt = 32'h0;
    end
  endcase
end
// ===============================================
// Sequencer state
always @(posedge ref_clk or posedge rst) begin
  if (rst) begin
    state <= ST_IDLE;
    busy_cnt <= 32'h0;
  end else begin
    // The counter is cleared when ee_done ends a store or restore and counts up in the hold state; elsewhere it keeps its last value.
    state <= next_state;
    busy_cnt <= next_busy_cnt;
  end
end
// ===============================================
// Write answers
always @(posedge ref_clk or posedge rst) begin
  if (rst) begin
    wr_accept <= 1'b0;
    wr_block <= 1'b0;
  end else begin
    // A refused write only answers with wr_block; nothing it names is touched.
    wr_accept <= wr_take;
    wr_block <= wr_go && !permit;
  end
end
// ===============================================
// EEPROM requests
always @(posedge ref_clk or posedge rst) begin
  if (rst) begin
    ee_store_req <= 1'b0;
    ee_restore_req <= 1'b0;
    restart_req <= 1'b0;
    bus_nack <= 1'b0;
  end else begin
    // A restore while switching asks the power stage for a restart.
    ee_store_req <= wr_is_store;
    ee_restore_req <= wr_is_restore;
    restart_req <= wr_is_restore && switching;
    bus_nack <= ee_finish && ee_fail;
  end
end
// ===============================================
// Fault masking during a store
always @(posedge ref_clk or posedge rst) begin
  if (rst) begin
    fault_ignore <= 1'b0;
  end else if (wr_is_store) begin
    // Samples switching at the store command so that a converter idle then never masks its faults.
    fault_ignore <= switching;
  end else if (ee_finish) begin
    fault_ignore <= 1'b0;
  end
end
// ===============================================
// Guard register
always @(posedge ref_clk or posedge rst) begin
  if (rst) begin
    write_guard_level <= `PWG_GUARD_RESET;
  end else if (wr_is_guard) begin
    write_guard_level <= wr_data;
  end else if (ee_finish && (state == ST_RESTORE) && !ee_fail) begin
    // The stored image includes the guard byte; a restore that does not fail reloads it too.
    write_guard_level <= ee_guard_value;
  end
end
// ===============================================
// Sticky error flags
always @(posedge ref_clk or posedge rst) begin
  if (rst) begin
    cml_flag <= 1'b0;
    mem_flag <= 1'b0;
    ivd_flag <= 1'b0;
  end else begin
    // Only reset clears the flags; no bus command clears them once they are set.
    if (wr_is_guard && guard_multi) begin
      cml_flag <= 1'b1;
    end
    if (wr_is_mask && !wr_idx_ok) begin
      cml_flag <= 1'b1;
      ivd_flag <= 1'b1;
    end
    if (ee_finish && ee_fail) begin
      cml_flag <= 1'b1;
      mem_flag <= 1'b1;
    end
  end
end
// ===============================================
// Alert mask store
always @(posedge ref_clk or posedge rst) begin
  if (rst) begin
    for (k = 0; k < NUM_STATUS; k = k + 1) begin
      mask_mem[k] <= `PWG_MASK_RESET;
    end
  end else if (wr_is_mask && wr_idx_ok) begin
    // Codes outside the supported list never reach the array; they only raise flags.
    mask_mem[wr_idx] <= wr_data;
  end
end
// ===============================================
// Read path
always @(posedge ref_clk or posedge rst) begin
  if (rst) begin
    rd_valid <= 1'b0;
    rd_data <= 8'h00;
  end else begin
    // Reads are never gated by the guard level; only bus busy time silences them.
    rd_valid <= rd_go;
    if (rd_go) begin
      case (rd_cmd)
        `PWG_CMD_WRITE_GUARD: begin
          rd_data <= write_guard_level;
        end
        `PWG_CMD_FEATURE_REPORT: begin
          rd_data <= `PWG_FEATURE_VALUE;
        end
        `PWG_CMD_ALERT_MASK: begin
          rd_data <= rd_idx_ok ? mask_mem[rd_idx] : 8'h00;
        end
        default: begin
          rd_data <= 8'h00;
        end
      endcase
    end
  end
end
// ===============================================
// Busy and alert outputs
always @* begin
  bus_busy = (state != ST_IDLE);
  alert = cml_flag || (|masked_hits);
end
endmodule // pwg_write_guard

// File: sim/pwg_write_guard_properties.sv
// Concurrent checks on the write guard core, bound to its ports.
// Assumes one clock, ref_clk, and rst asynchronous and active high.
`timescale 1ns/100ps
module pwg_write_guard_checker (
  input wire ref_clk, input wire rst, input wire wr_strobe, input wire [7:0] wr_cmd,
  input wire [7:0] wr_data, input wire rd_strobe, input wire [7:0] rd_cmd,
  input wire ee_done, input wire ee_fail, input wire switching, input wire [7:0] rd_data,
  input wire rd_valid, input wire wr_accept, input wire wr_block, input wire bus_nack,
  input wire bus_busy, input wire ee_store_req, input wire fault_ignore,
  input wire [7:0] write_guard_level, input wire cml_flag, input wire mem_flag,
  input wire alert
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire wr_go = wr_strobe && !bus_busy;
  a_feature_read: assert property (
    rd_strobe && !bus_busy && rd_cmd == 8'h19 |=> rd_valid && rd_data == 8'hb0
  ) else $error("feature byte wrong");
  a_top_level: assert property (
    wr_go && write_guard_level == 8'h80 && wr_cmd != 8'h10 |=> wr_block && !wr_accept
  ) else $error("top level let a write through");
  a_mid_level: assert property (
    wr_go && write_guard_level == 8'h40 && !(wr_cmd inside {8'h10, 8'h01}) |=> wr_block
  ) else $error("mid level let a write through");
  a_low_level: assert property (
    wr_go && write_guard_level == 8'h20 && !(wr_cmd inside {8'h10, 8'h01, 8'h02, 8'h21})
    |=> wr_block
  ) else $error("low level let a write through");
  a_open_level: assert property (
    wr_go && !$onehot(write_guard_level[7:5]) |=> wr_accept && !wr_block
  ) else $error("unguarded write refused");
  a_multi_bit: assert property (
    wr_go && wr_cmd == 8'h10 && !$onehot0(wr_data[7:5]) |=> cml_flag && alert
  ) else $error("bad guard byte not flagged");
  a_fail_flags: assert property (
    ee_done && ee_fail && bus_busy |=> bus_nack && cml_flag && mem_flag
  ) else $error("store failure not reported");
  a_store_start: assert property (
    wr_go && wr_cmd == 8'h11 && !$onehot(write_guard_level[7:5])
    |=> ee_store_req && bus_busy && fault_ignore == $past(switching)
  ) else $error("store did not start");
endmodule // pwg_write_guard_checker

bind pwg_write_guard pwg_write_guard_checker chk_u (.ref_clk, .rst, .wr_strobe, .wr_cmd,
  .wr_data, .rd_strobe, .rd_cmd, .ee_done, .ee_fail, .switching, .rd_data, .rd_valid,
  .wr_accept, .wr_block, .bus_nack, .bus_busy, .ee_store_req, .fault_ignore,
  .write_guard_level, .cml_flag, .mem_flag, .alert);

// File: sim/pwg_ee_model.sv
// Behavioural EEPROM engine answering store and restore requests.
// Assumes one-cycle requests; dly sets how slowly it answers.
`timescale 1ns/100ps
module pwg_ee_model (
  input wire ref_clk, input wire rst, input wire ee_store_req, input wire ee_restore_req,
  input wire [7:0] write_guard_level, input wire fail_next, input wire [3:0] dly,
  output reg ee_done, output wire ee_fail, output wire [7:0] ee_guard_value
);
  reg [7:0] saved;
  reg [3:0] cnt;
  // Outside the done pulse the byte is inverted so a stale sample shows up.
  assign ee_guard_value = ee_done ? saved : ~saved;
  assign ee_fail = ee_done & fail_next;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      saved <= 8'h00;
      cnt <= 4'h0;
      ee_done <= 1'b0;
    end else begin
      ee_done <= cnt == 4'h1;
      if (ee_store_req) saved <= write_guard_level;
      if (ee_store_req || ee_restore_req) cnt <= dly;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule // pwg_ee_model

// File: sim/pwg_write_guard_bench.sv
// Self-checking bench for the write guard core with the EEPROM model beside it.
// Assumes strobes of one cycle; busy time is shortened to 8 cycles.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module pwg_write_guard_bench;
  reg ref_clk = 1'b0, rst = 1'b1, wr_strobe = 1'b0, rd_strobe = 1'b0;
  reg switching = 1'b0, fail_next = 1'b0;
  reg [7:0] wr_cmd = 8'h00, wr_data = 8'h00, rd_cmd = 8'h00;
  reg [7:0] wr_mask_code = 8'h00, rd_mask_code = 8'h00;
  reg [3:0] dly = 4'h1;
  reg [1:0] seen;
  reg [55:0] status_conditions = 56'h0;
  wire [7:0] rd_data, ee_guard_value, write_guard_level;
  wire [2:0] restore_allow;
  wire rd_valid, wr_accept, wr_block, bus_nack, bus_busy, ee_store_req, ee_restore_req;
  wire fault_ignore, restart_req, cml_flag, mem_flag, ivd_flag, alert, ee_done, ee_fail;
  int errors = 0, num_checks = 0, cyc = 0;
  always #10 ref_clk = ~ref_clk;
  pwg_write_guard #(.BUSY_CYCLES(8)) dut_u (.ref_clk, .rst, .wr_strobe, .wr_cmd, .wr_data,
    .wr_mask_code, .rd_strobe, .rd_cmd, .rd_mask_code, .ee_guard_value, .ee_done, .ee_fail,
    .switching, .status_conditions, .rd_data, .rd_valid, .wr_accept, .wr_block, .bus_nack,
    .bus_busy, .ee_store_req, .ee_restore_req, .restore_allow, .fault_ignore, .restart_req,
    .write_guard_level, .cml_flag, .mem_flag, .ivd_flag, .alert);
  pwg_ee_model ee_u (.ref_clk, .rst, .ee_store_req, .ee_restore_req, .write_guard_level,
    .fail_next, .dly, .ee_done, .ee_fail, .ee_guard_value);
  // ==========================================================
  // Bus tasks
  task automatic req(input w, input [7:0] c, input [7:0] d);
    @(negedge ref_clk);
    wr_cmd = c;
    rd_cmd = c;
    wr_data = d;
    wr_strobe = w;
    rd_strobe = !w;
    @(negedge ref_clk);
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
  endtask
  task automatic idle;
    for (int i = 0; i < 40 && bus_busy; i++) begin
      @(negedge ref_clk);
      seen = seen | {restart_req, bus_nack};
    end
    `CHK(bus_busy, 1'b0)
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_levels;
    logic [7:0] lv [3] = '{8'h80, 8'h40, 8'h20};
    logic [7:0] cm [4] = '{8'h01, 8'h02, 8'h21, 8'h29};
    logic ok;
    foreach (lv[i]) begin
      req(1'b1, 8'h10, lv[i]);
      `CHK(restore_allow, {lv[i] == 8'h20, lv[i] != 8'h80, 1'b1})
      for (int j = 0; j < 4; j++) begin
        req(1'b1, cm[j], 8'h00);
        ok = lv[i] == 8'h20 && j < 3 || lv[i] == 8'h40 && j == 0;
        `CHK({wr_accept, wr_block}, {ok, !ok})
      end
      req(1'b1, 8'h11, 8'h00);
      `CHK({wr_block, ee_store_req, bus_busy}, 3'b100)
      req(1'b0, 8'h19, 8'h00);
      `CHK({rd_valid, rd_data}, 9'h1b0)
    end
    req(1'b1, 8'h10, 8'h00);
    `CHK(wr_accept, 1'b1)
  endtask
  task automatic t_mask;
    @(negedge ref_clk);
    status_conditions = 56'h00000040000000;
    wr_mask_code = 8'h7c;
    rd_mask_code = 8'h7c;
    @(negedge ref_clk);
    `CHK(alert, 1'b1)
    req(1'b1, 8'h1b, 8'h40);
    `CHK({wr_accept, alert}, 2'b10)
    req(1'b0, 8'h1b, 8'h00);
    `CHK({rd_valid, rd_data}, 9'h140)
    rd_mask_code = 8'h7f;
    req(1'b0, 8'h1b, 8'h00);
    `CHK({rd_valid, rd_data}, 9'h100)
    wr_mask_code = 8'h20;
    req(1'b1, 8'h1b, 8'h55);
    `CHK({cml_flag, ivd_flag, alert}, 3'b111)
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    `CHK({cml_flag, ivd_flag, alert, write_guard_level}, 11'h100)
    status_conditions = 56'h0;
  endtask
  task automatic t_store;
    req(1'b1, 8'h10, 8'he0);
    `CHK({wr_accept, cml_flag, alert}, 3'b111)
    switching = 1'b1;
    dly = 4'hc;
    req(1'b1, 8'h11, 8'h00);
    `CHK({ee_store_req, bus_busy, fault_ignore}, 3'b111)
    req(1'b0, 8'h19, 8'h00);
    `CHK(rd_valid, 1'b0)
    idle();
    `CHK(fault_ignore, 1'b0)
  endtask
  task automatic t_restore;
    req(1'b1, 8'h10, 8'h00);
    dly = 4'h1;
    req(1'b1, 8'h12, 8'h00);
    seen = {restart_req, 1'b0};
    `CHK(ee_restore_req, 1'b1)
    idle();
    `CHK({seen[1], write_guard_level}, 9'h1e0)
    switching = 1'b0;
    fail_next = 1'b1;
    req(1'b1, 8'h11, 8'h00);
    `CHK({ee_store_req, fault_ignore}, 2'b10)
    seen = 2'b00;
    idle();
    `CHK({seen[0], mem_flag}, 2'b11)
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    req(1'b0, 8'h19, 8'h00);
    `CHK({rd_valid, rd_data, write_guard_level}, 17'h1b000)
    t_levels();
    t_mask();
    t_store();
    t_restore();
    summarize();
  end
endmodule // pwg_write_guard_bench
